/* esrb_bank.sv */
// esrb_bank: envelope service register bank with measurement pacing
//
// Function
// R1 - pacing code 1 times sweeps from precise sensor timing at programmed rate
// R2 - pacing code 2 limits sweep rate by software-style pacing at programmed rate
// R3 - in software pacing a zero rate removes the limit entirely
// R4 - rate register counts in steps of one millihertz
// R5 - amplification accepts 0 to 1000, lowest to highest
// R6 - energy code 0 shuts whole sensor down between sweeps
// R7 - energy code 1 selects sleep, code 2 selects ready
// R8 - energy code 3 keeps whole sensor active
// R9 - hibernate needs the application to toggle a pin, outside this block
// R10 - hibernate energy code is refused by the envelope service
// R11 - pulse profile accepts codes 1 to 5 only
// R12 - unambiguous span accepts only codes 6 and 9
// R13 - noise floor scaling is enabled after reset
// R14 - averaging weight accepts 0 to 1000, zero disables filtering
// R15 - writable words hold configuration, read-only words hold refreshed metadata
// R16 - range and sweep words in millimetres, point spacing in micrometres
// R17 - saturation flag set when sensor data saturates
// R18 - overrun flag set when measurement data was lost
// R19 - quality alert flag set on poor data quality
// R20 - link fault flag set on sensor communication error
// R21 - host writes to read-only words are ignored
// R22 - every register is a 32-bit word, unused bits read zero
`timescale 1ns/1ps
module esrb_bank #(
    parameter int unsigned   ADDR_W   = esrb_pkg::ADDR_W,
    parameter int unsigned   DATA_W   = esrb_pkg::DATA_W,
    parameter logic [63:0]   CLK_MHZ  = esrb_pkg::CLK_MILLIHZ
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    // register port
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    // measurement engine side
    input  wire esrb_pkg::esrb_meta_s meta_in,
    input  wire logic                meta_load,
    input  wire esrb_pkg::esrb_evt_s evt_in,
    input  wire logic                status_clear,
    input  wire logic                sweep_done,
    output esrb_pkg::esrb_cfg_s      cfg_out,
    output logic                     sweep_start,
    output logic                     sensor_paced
);

    typedef enum logic [1:0] {
        ESRB_IDLE  = 2'b00,
        ESRB_WAIT  = 2'b01,
        ESRB_BUSY  = 2'b10
    } esrb_pace_e;

    // value check for 0..1000 scale registers
    function automatic logic esrb_in_scale(input logic [DATA_W-1:0] v);
        return v <= esrb_pkg::SCALE_LIMIT;
    endfunction : esrb_in_scale

    // cycles per sweep at a rate in millihertz; zero rate yields zero
    function automatic logic [63:0] esrb_period(input logic [DATA_W-1:0] rate);
        return (rate == esrb_pkg::ZERO_WORD) ? 64'h0 : CLK_MHZ / 64'(rate);
    endfunction : esrb_period

    // configuration registers
    esrb_pkg::esrb_cfg_s cfg_reg, cfg_next;
    logic [DATA_W-1:0]   pacing_reg, pacing_next;
    logic [DATA_W-1:0]   rate_reg, rate_next;
    // metadata and sticky status
    esrb_pkg::esrb_meta_s meta_reg, meta_next;
    esrb_pkg::esrb_evt_s  flag_reg, flag_next;
    // read path
    logic [DATA_W-1:0]   rdata_reg, rdata_next;
    // pacing engine
    esrb_pace_e          pace_reg, pace_next;
    logic [63:0]         cnt_reg, cnt_next;
    logic                start_reg, start_next;
    logic                paced_reg, paced_next;

    logic                wr_hit;
    assign wr_hit = reg_wr;

    // configuration writes; out-of-range codes leave the old value in place
    always_comb begin
        cfg_next    = cfg_reg;
        pacing_next = pacing_reg;
        rate_next   = rate_reg;
        if (wr_hit) begin
            unique case (reg_addr)
                esrb_pkg::IDX_MEASURE_BEGIN: cfg_next.begin_mm = reg_wdata;       // [R16] [R15]
                esrb_pkg::IDX_MEASURE_SPAN:  cfg_next.span_mm  = reg_wdata;       // [R16]
                esrb_pkg::IDX_PACING: begin
                    if (reg_wdata == esrb_pkg::PACING_SENSOR || reg_wdata == esrb_pkg::PACING_SOFT) begin
                        pacing_next = reg_wdata;
                    end
                end
                esrb_pkg::IDX_FREQ_MHZ:      rate_next = reg_wdata;               // [R4]
                esrb_pkg::IDX_AMPLIFICATION: begin
                    if (esrb_in_scale(reg_wdata)) begin
                        cfg_next.amplification = reg_wdata;                       // [R5]
                    end
                end
                esrb_pkg::IDX_ENERGY_STATE: begin
                    // codes 0..3 accepted; hibernate and above refused
                    if (reg_wdata <= esrb_pkg::ENERGY_ACTIVE) begin               // [R6] [R7] [R8] [R10]
                        cfg_next.energy_state = reg_wdata;
                    end
                end
                esrb_pkg::IDX_TX_MUTE:       cfg_next.tx_mute = reg_wdata[0];
                esrb_pkg::IDX_PROFILE: begin
                    if (reg_wdata >= esrb_pkg::PROFILE_MIN && reg_wdata <= esrb_pkg::PROFILE_MAX) begin
                        cfg_next.profile = reg_wdata;                             // [R11]
                    end
                end
                esrb_pkg::IDX_DECIMATION:    cfg_next.decimation = reg_wdata;
                esrb_pkg::IDX_AVG_COUNT:     cfg_next.avg_count  = reg_wdata;
                esrb_pkg::IDX_NOISE_SCALE:   cfg_next.noise_scale = reg_wdata[0];
                esrb_pkg::IDX_ATTEN_MAX:     cfg_next.atten_max   = reg_wdata[0];
                esrb_pkg::IDX_FREE_RUN:      cfg_next.free_run    = reg_wdata[0];
                esrb_pkg::IDX_UNAMB_SPAN: begin
                    if (reg_wdata == esrb_pkg::UNAMB_SHORT || reg_wdata == esrb_pkg::UNAMB_LONG) begin
                        cfg_next.unamb_span = reg_wdata;                          // [R12]
                    end
                end
                esrb_pkg::IDX_AVG_WEIGHT: begin
                    if (esrb_in_scale(reg_wdata)) begin
                        cfg_next.avg_weight = reg_wdata;                          // [R14]
                    end
                end
                default: ;                                                        // [R21]
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_reg             <= '0;
            cfg_reg.energy_state <= esrb_pkg::RST_ENERGY;
            cfg_reg.profile     <= esrb_pkg::RST_PROFILE;
            cfg_reg.decimation  <= esrb_pkg::RST_DECIMATION;
            cfg_reg.avg_count   <= esrb_pkg::RST_AVG_COUNT;
            cfg_reg.noise_scale <= esrb_pkg::RST_NOISE_SCALE[0];                  // [R13]
            cfg_reg.unamb_span  <= esrb_pkg::RST_UNAMB;
            pacing_reg          <= esrb_pkg::RST_PACING;
            rate_reg            <= esrb_pkg::ZERO_WORD;
        end else begin
            cfg_reg             <= cfg_next;
            pacing_reg          <= pacing_next;
            rate_reg            <= rate_next;
        end
    end

    // metadata and sticky flags: engine only, host writes have no path here
    always_comb begin
        meta_next = meta_reg;
        flag_next = flag_reg;
        if (meta_load) begin
            meta_next = meta_in;                                                  // [R15] [R21]
        end
        // clear first, then events, so a same-cycle event survives the clear
        if (status_clear) begin
            flag_next = '0;
        end
        flag_next.saturated  = flag_next.saturated  | evt_in.saturated;          // [R17]
        flag_next.overrun    = flag_next.overrun    | evt_in.overrun;            // [R18]
        flag_next.quality    = flag_next.quality    | evt_in.quality;            // [R19]
        flag_next.link_fault = flag_next.link_fault | evt_in.link_fault;         // [R20]
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            flag_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            flag_reg <= flag_next;
        end
    end

    // read mux; single-bit fields zero-extend, unmapped reads return zero
    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                esrb_pkg::IDX_MEASURE_BEGIN: rdata_next = cfg_reg.begin_mm;
                esrb_pkg::IDX_MEASURE_SPAN:  rdata_next = cfg_reg.span_mm;
                esrb_pkg::IDX_PACING:        rdata_next = pacing_reg;
                esrb_pkg::IDX_FREQ_MHZ:      rdata_next = rate_reg;
                esrb_pkg::IDX_AMPLIFICATION: rdata_next = cfg_reg.amplification;
                esrb_pkg::IDX_ENERGY_STATE:  rdata_next = cfg_reg.energy_state;
                esrb_pkg::IDX_TX_MUTE:       rdata_next = {31'h0, cfg_reg.tx_mute};    // [R22]
                esrb_pkg::IDX_PROFILE:       rdata_next = cfg_reg.profile;
                esrb_pkg::IDX_DECIMATION:    rdata_next = cfg_reg.decimation;
                esrb_pkg::IDX_AVG_COUNT:     rdata_next = cfg_reg.avg_count;
                esrb_pkg::IDX_NOISE_SCALE:   rdata_next = {31'h0, cfg_reg.noise_scale};
                esrb_pkg::IDX_ATTEN_MAX:     rdata_next = {31'h0, cfg_reg.atten_max};
                esrb_pkg::IDX_FREE_RUN:      rdata_next = {31'h0, cfg_reg.free_run};
                esrb_pkg::IDX_UNAMB_SPAN:    rdata_next = cfg_reg.unamb_span;
                esrb_pkg::IDX_AVG_WEIGHT:    rdata_next = cfg_reg.avg_weight;
                esrb_pkg::IDX_SWEEP_ORIGIN:  rdata_next = meta_reg.origin_mm;          // [R16]
                esrb_pkg::IDX_SWEEP_EXTENT:  rdata_next = meta_reg.extent_mm;
                esrb_pkg::IDX_WORD_COUNT:    rdata_next = meta_reg.word_count;
                esrb_pkg::IDX_JOIN_COUNT:    rdata_next = meta_reg.join_count;
                esrb_pkg::IDX_POINT_SPACING: rdata_next = meta_reg.spacing_um;         // [R16]
                esrb_pkg::IDX_SATURATION:    rdata_next = {31'h0, flag_reg.saturated};
                esrb_pkg::IDX_OVERRUN:       rdata_next = {31'h0, flag_reg.overrun};
                esrb_pkg::IDX_QUALITY:       rdata_next = {31'h0, flag_reg.quality};
                esrb_pkg::IDX_LINK_FAULT:    rdata_next = {31'h0, flag_reg.link_fault};
                default:                     rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // pacing: sweep_start pulses once per period; in sensor pacing the period
    // is counted strictly from start to start, in soft pacing it is a minimum
    // gap counted from start but the next start also waits for sweep_done
    always_comb begin
        pace_next  = pace_reg;
        cnt_next   = cnt_reg;
        start_next = 1'b0;
        paced_next = (pacing_reg == esrb_pkg::PACING_SENSOR);                     // [R1]
        unique case (pace_reg)
            ESRB_IDLE: begin
                start_next = 1'b1;
                cnt_next   = esrb_period(rate_reg);                               // [R4]
                pace_next  = ESRB_BUSY;
            end
            ESRB_BUSY: begin
                if (cnt_reg != 64'h0) begin
                    cnt_next = cnt_reg - 64'h1;
                end
                if (paced_next) begin
                    // leave one count early: the idle cycle then makes the period exactly the count
                    if (cnt_reg <= 64'h2) begin                                   // [R1]
                        pace_next = ESRB_IDLE;
                    end
                end else if (sweep_done) begin
                    pace_next = ESRB_WAIT;                                        // [R2]
                end
            end
            ESRB_WAIT: begin
                if (cnt_reg != 64'h0) begin
                    cnt_next = cnt_reg - 64'h1;
                end
                // zero rate loads zero, so the next sweep follows at once
                if (cnt_reg <= 64'h2) begin                                       // [R2] [R3]
                    pace_next = ESRB_IDLE;
                end
            end
            default: pace_next = ESRB_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pace_reg  <= ESRB_WAIT;
            cnt_reg   <= 64'h0;
            start_reg <= 1'b0;
            paced_reg <= 1'b0;
        end else begin
            pace_reg  <= pace_next;
            cnt_reg   <= cnt_next;
            start_reg <= start_next;
            paced_reg <= paced_next;
        end
    end

    assign reg_rdata    = rdata_reg;
    assign cfg_out      = cfg_reg;
    assign sweep_start  = start_reg;
    assign sensor_paced = paced_reg;

endmodule : esrb_bank

/* esrb_pkg.sv */
// esrb_pkg: offsets, codes, reset values and structs for the envelope register bank
package esrb_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register indices, byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_MEASURE_BEGIN  = 8'h20;
    localparam logic [ADDR_W-1:0] IDX_MEASURE_SPAN   = 8'h21;
    localparam logic [ADDR_W-1:0] IDX_PACING         = 8'h22;
    localparam logic [ADDR_W-1:0] IDX_FREQ_MHZ       = 8'h23;
    localparam logic [ADDR_W-1:0] IDX_AMPLIFICATION  = 8'h24;
    localparam logic [ADDR_W-1:0] IDX_ENERGY_STATE   = 8'h25;
    localparam logic [ADDR_W-1:0] IDX_TX_MUTE        = 8'h26;
    localparam logic [ADDR_W-1:0] IDX_PROFILE        = 8'h28;
    localparam logic [ADDR_W-1:0] IDX_DECIMATION     = 8'h29;
    localparam logic [ADDR_W-1:0] IDX_AVG_COUNT      = 8'h30;
    localparam logic [ADDR_W-1:0] IDX_NOISE_SCALE    = 8'h31;
    localparam logic [ADDR_W-1:0] IDX_ATTEN_MAX      = 8'h32;
    localparam logic [ADDR_W-1:0] IDX_FREE_RUN       = 8'h33;
    localparam logic [ADDR_W-1:0] IDX_UNAMB_SPAN     = 8'h34;
    localparam logic [ADDR_W-1:0] IDX_AVG_WEIGHT     = 8'h40;
    localparam logic [ADDR_W-1:0] IDX_SWEEP_ORIGIN   = 8'h81;
    localparam logic [ADDR_W-1:0] IDX_SWEEP_EXTENT   = 8'h82;
    localparam logic [ADDR_W-1:0] IDX_WORD_COUNT     = 8'h83;
    localparam logic [ADDR_W-1:0] IDX_JOIN_COUNT     = 8'h84;
    localparam logic [ADDR_W-1:0] IDX_POINT_SPACING  = 8'h85;
    localparam logic [ADDR_W-1:0] IDX_SATURATION     = 8'ha0;
    localparam logic [ADDR_W-1:0] IDX_OVERRUN        = 8'ha1;
    localparam logic [ADDR_W-1:0] IDX_QUALITY        = 8'ha3;
    localparam logic [ADDR_W-1:0] IDX_LINK_FAULT     = 8'ha4;

    // code values
    localparam logic [DATA_W-1:0] PACING_SENSOR      = 32'h0000_0001;
    localparam logic [DATA_W-1:0] PACING_SOFT        = 32'h0000_0002;
    localparam logic [DATA_W-1:0] ENERGY_OFF         = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ENERGY_ACTIVE      = 32'h0000_0003;
    localparam logic [DATA_W-1:0] PROFILE_MIN        = 32'h0000_0001;
    localparam logic [DATA_W-1:0] PROFILE_MAX        = 32'h0000_0005;
    localparam logic [DATA_W-1:0] UNAMB_SHORT        = 32'h0000_0006;
    localparam logic [DATA_W-1:0] UNAMB_LONG         = 32'h0000_0009;
    localparam logic [DATA_W-1:0] SCALE_LIMIT        = 32'h0000_03e8;  // 1000
    localparam logic [DATA_W-1:0] ZERO_WORD          = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ONE_WORD           = 32'h0000_0001;

    // reset values, plain defaults
    localparam logic [DATA_W-1:0] RST_PACING         = PACING_SENSOR;
    localparam logic [DATA_W-1:0] RST_ENERGY         = ENERGY_ACTIVE;
    localparam logic [DATA_W-1:0] RST_PROFILE        = PROFILE_MIN;
    localparam logic [DATA_W-1:0] RST_UNAMB          = UNAMB_SHORT;
    localparam logic [DATA_W-1:0] RST_NOISE_SCALE    = ONE_WORD;
    localparam logic [DATA_W-1:0] RST_DECIMATION     = ONE_WORD;
    localparam logic [DATA_W-1:0] RST_AVG_COUNT      = ONE_WORD;

    // pacing tick arithmetic: 1 mHz steps at 200 MHz clock
    localparam int unsigned       CLK_HZ             = 200_000_000;
    localparam int unsigned       MHZ_PER_HZ         = 1000;
    localparam logic [63:0]       CLK_MILLIHZ        = 64'(CLK_HZ) * 64'(MHZ_PER_HZ);

    // configuration carried to the measurement engine
    typedef struct packed {
        logic [DATA_W-1:0] begin_mm;
        logic [DATA_W-1:0] span_mm;
        logic [DATA_W-1:0] amplification;
        logic [DATA_W-1:0] energy_state;
        logic              tx_mute;
        logic [DATA_W-1:0] profile;
        logic [DATA_W-1:0] decimation;
        logic [DATA_W-1:0] avg_count;
        logic              noise_scale;
        logic              atten_max;
        logic              free_run;
        logic [DATA_W-1:0] unamb_span;
        logic [DATA_W-1:0] avg_weight;
    } esrb_cfg_s;

    // metadata from the measurement engine
    typedef struct packed {
        logic [DATA_W-1:0] origin_mm;
        logic [DATA_W-1:0] extent_mm;
        logic [DATA_W-1:0] word_count;
        logic [DATA_W-1:0] join_count;
        logic [DATA_W-1:0] spacing_um;
    } esrb_meta_s;

    // status events, one-cycle pulses from the engine
    typedef struct packed {
        logic saturated;
        logic overrun;
        logic quality;
        logic link_fault;
    } esrb_evt_s;
endpackage : esrb_pkg

/* esrb_bank_chk.sv */
// esrb_bank_chk: port-level assertions for the envelope register bank
`timescale 1ns/1ps
module esrb_bank_chk (
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 reset_n,
    // register port
    input wire logic [7:0]           reg_addr,
    input wire logic [31:0]          reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    // engine side
    input wire esrb_pkg::esrb_meta_s meta_in,
    input wire logic                 meta_load,
    input wire esrb_pkg::esrb_evt_s  evt_in,
    input wire logic                 status_clear,
    input wire logic                 sweep_done,
    input wire esrb_pkg::esrb_cfg_s  cfg_out,
    input wire logic                 sweep_start,
    input wire logic                 sensor_paced
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // reads a few cycles after their cause
    sequence s_ovr_read;
        evt_in.overrun ##[1:8] (reg_rd && reg_addr == esrb_pkg::IDX_OVERRUN);
    endsequence
    sequence s_meta_read;
        meta_load ##[1:3] (reg_rd && reg_addr == esrb_pkg::IDX_WORD_COUNT);
    endsequence
    property p_rd_quiet;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero outside its slot");
    property p_amp_take;
        reg_wr && reg_addr == esrb_pkg::IDX_AMPLIFICATION && reg_wdata <= 32'h3e8 |=> cfg_out.amplification == $past(reg_wdata);
    endproperty
    a_amp_take: assert property (p_amp_take) else $error("legal amplification not taken");
    property p_energy_keep;
        reg_wr && reg_addr == esrb_pkg::IDX_ENERGY_STATE && reg_wdata > 32'h3 |=> $stable(cfg_out.energy_state);
    endproperty
    a_energy_keep: assert property (p_energy_keep) else $error("energy code above 3 was taken");
    property p_profile_keep;
        reg_wr && reg_addr == esrb_pkg::IDX_PROFILE && (reg_wdata < 32'h1 || reg_wdata > 32'h5) |=> $stable(cfg_out.profile);
    endproperty
    a_profile_keep: assert property (p_profile_keep) else $error("profile outside 1 to 5 was taken");
    property p_unamb_keep;
        reg_wr && reg_addr == esrb_pkg::IDX_UNAMB_SPAN && !(reg_wdata inside {32'h6, 32'h9}) |=> $stable(cfg_out.unamb_span);
    endproperty
    a_unamb_keep: assert property (p_unamb_keep) else $error("span code other than 6 or 9 was taken");
    property p_paced_soft;
        reg_wr && reg_addr == esrb_pkg::IDX_PACING && reg_wdata == 32'h2 |-> ##[1:2] !sensor_paced;
    endproperty
    a_paced_soft: assert property (p_paced_soft) else $error("soft pacing left sensor pacing on");
    property p_ovr_sticky;
        s_ovr_read |=> reg_rdata == 32'h1;
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun flag not held after event");
    property p_meta_word;
        s_meta_read |=> reg_rdata == meta_in.word_count;
    endproperty
    a_meta_word: assert property (p_meta_word) else $error("loaded word count not read back");
endmodule : esrb_bank_chk

bind esrb_bank esrb_bank_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meta_in(meta_in),
    .meta_load(meta_load), .evt_in(evt_in), .status_clear(status_clear), .sweep_done(sweep_done),
    .cfg_out(cfg_out), .sweep_start(sweep_start), .sensor_paced(sensor_paced));

/* esrb_engine_model.sv */
// esrb_engine_model: measurement engine stand-in that ends each sweep after a set delay
`timescale 1ns/1ps
module esrb_engine_model (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       reset_n,
    // sweep handshake
    input wire logic       sweep_start,
    input wire logic [7:0] lat,
    output logic           sweep_done
);
    logic [7:0] cnt;
    // starts while busy are dropped, as a real engine cannot run two sweeps at once
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 8'h00;
            sweep_done <= 1'b0;
        end else begin
            sweep_done <= (cnt == 8'h01);
            cnt <= (cnt != 8'h00) ? cnt - 8'h01 : (sweep_start ? lat : 8'h00);
        end
    end
endmodule : esrb_engine_model

/* tb.sv */
// tb: self-checking bench for the envelope register bank
`timescale 1ns/1ps
module tb;
    // lowered clock figure: a 10 Hz rate then gives a 10-cycle period
    localparam logic [63:0] CLK_MHZ = 64'd100000;
    localparam logic [7:0]  IDX [25] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h28, 8'h29, 8'h30,
        8'h31, 8'h32, 8'h33, 8'h34, 8'h40, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'ha0, 8'ha1, 8'ha3, 8'ha4, 8'h27};
    localparam logic [7:0]  CODED [4] = '{8'h22, 8'h25, 8'h28, 8'h34};
    localparam logic [7:0]  FLAG [4] = '{8'ha0, 8'ha1, 8'ha3, 8'ha4};
    localparam logic [7:0]  ONES [5] = '{8'h22, 8'h28, 8'h29, 8'h30, 8'h31};
    localparam logic [31:0] BOUND [5] = '{32'h0, 32'h3e7, 32'h3e8, 32'h3e9, 32'hffff_ffff};
    logic                 ref_clk, reset_n, reg_wr, reg_rd, meta_load, status_clear, sweep_done, sweep_start;
    logic                 sensor_paced;
    logic [7:0]           reg_addr, lat;
    logic [31:0]          reg_wdata, reg_rdata, shadow [256];
    esrb_pkg::esrb_meta_s meta_in;
    esrb_pkg::esrb_evt_s  evt_in;
    esrb_pkg::esrb_cfg_s  cfg_out;
    int                   err_total = 0, n_compared = 0, g;

    esrb_bank #(.CLK_MHZ(CLK_MHZ)) DUT (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meta_in(meta_in),
        .meta_load(meta_load), .evt_in(evt_in), .status_clear(status_clear), .sweep_done(sweep_done),
        .cfg_out(cfg_out), .sweep_start(sweep_start), .sensor_paced(sensor_paced));
    esrb_engine_model u_eng (.ref_clk(ref_clk), .reset_n(reset_n), .sweep_start(sweep_start), .lat(lat),
        .sweep_done(sweep_done));

    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] ad);
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b1, ad};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, shadow[ad]);
    endtask : rchk

    // word a write leaves: refused codes keep the old one
    function automatic logic [31:0] store(input logic [7:0] ad, input logic [31:0] d, input logic [31:0] old);
        case (ad)
            8'h22: return (d == 32'h1 || d == 32'h2) ? d : old;
            8'h24, 8'h40: return (d <= 32'h3e8) ? d : old;
            8'h25: return (d <= 32'h3) ? d : old;
            8'h28: return (d >= 32'h1 && d <= 32'h5) ? d : old;
            8'h34: return (d == 32'h6 || d == 32'h9) ? d : old;
            8'h26, 8'h31, 8'h32, 8'h33: return {31'h0, d[0]};
            8'h20, 8'h21, 8'h23, 8'h29, 8'h30: return d;
            default: return old;
        endcase
    endfunction : store

    task automatic wr_rd(input logic [7:0] ad, input logic [31:0] d);
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, d};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        shadow[ad] = store(ad, d, shadow[ad]);
        rchk(ad);
    endtask : wr_rd

    // cycles up to and including the next start pulse, bounded
    task automatic wait_start(output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (sweep_start !== 1'b1 && n < 400);
        if (n >= 400) begin
            chk("start timeout", 32'h0, 32'h1);
            finish_test();
        end
    endtask : wait_start

    initial begin  // main sequence
        {reset_n, reg_wr, reg_rd, meta_load, status_clear, reg_addr, reg_wdata, meta_in, evt_in} = '0;
        lat = 8'd5;
        foreach (shadow[i]) shadow[i] = 32'h0;
        foreach (ONES[i]) shadow[ONES[i]] = 32'h1;
        shadow[8'h25] = 32'h3;
        shadow[8'h34] = 32'h6;
        void'($urandom(97779));
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        foreach (IDX[i]) rchk(IDX[i]);
        for (int c = 0; c < 11; c++) foreach (CODED[k]) wr_rd(CODED[k], 32'(c));
        foreach (BOUND[k]) wr_rd(8'h24, BOUND[k]);
        foreach (BOUND[k]) wr_rd(8'h40, BOUND[k]);
        // random traffic over the whole map, read-only and unmapped words included
        repeat (150) wr_rd(IDX[$urandom_range(0, 24)], $urandom_range(0, 1) ? $urandom : $urandom_range(0, 1010));
        // engine metadata load, then host writes that must bounce off it
        @(posedge ref_clk);
        {meta_in, meta_load} <= {$urandom, $urandom, $urandom, $urandom, $urandom, 1'b1};
        @(posedge ref_clk);
        meta_load <= 1'b0;
        {shadow[8'h81], shadow[8'h82], shadow[8'h83], shadow[8'h84], shadow[8'h85]} = meta_in;
        rchk(8'h83);
        for (int k = 8'h81; k < 8'h86; k++) wr_rd(8'(k), 32'hffff_ffff);
        // each event beats a same-cycle clear, then a lone clear drops it
        for (int f = 0; f < 4; f++) begin
            @(posedge ref_clk);
            {evt_in, status_clear} <= {4'(4'b1000 >> f), 1'b1};
            @(posedge ref_clk);
            {evt_in, status_clear} <= 5'h00;
            shadow[FLAG[f]] = 32'h1;
            foreach (FLAG[j]) rchk(FLAG[j]);
            @(posedge ref_clk);
            status_clear <= 1'b1;
            @(posedge ref_clk);
            status_clear <= 1'b0;
            shadow[FLAG[f]] = 32'h0;
            rchk(FLAG[f]);
        end
        @(posedge ref_clk);
        reset_n <= 1'b0;  // second reset drops a long count left by a slow random rate
        @(posedge ref_clk);
        reset_n <= 1'b1;
        // sensor pacing at 10000 mHz: 100000 / 10000 gives 10 cycles a period
        wr_rd(8'h23, 32'd10000);
        wr_rd(8'h22, 32'h1);
        wait_start(g);
        chk("sensor_paced", {31'h0, sensor_paced}, 32'h1);
        wait_start(g);
        chk("sensor gap", 32'(g == 10), 32'h1);
        wr_rd(8'h22, 32'h2);
        wait_start(g);
        chk("sensor_paced", {31'h0, sensor_paced}, 32'h0);
        wait_start(g);
        chk("soft gap", 32'(g >= 10 && g <= 20), 32'h1);
        // no limit: the next start follows the engine, prompt or slow
        wr_rd(8'h23, 32'h0);
        for (int s = 5; s < 30; s += 20) begin
            lat = 8'(s);
            wait_start(g);
            wait_start(g);
            chk("unlimited gap", 32'(g >= s && g <= s + 4), 32'h1);
        end
        finish_test();
    end
endmodule : tb
